// ---- verilog/dac_ctl_pkg.sv ----
// Purpose: shared constants of the converter update, reset and alarm control
// Assumes: 7-bit register addresses, byte-wide registers, 16-bit output code
// Notes:   offsets, field positions, reset values and timing counts live here
`default_nettype none
package dac_ctl_pkg;
  // register map
  localparam logic [6:0] A_CFG_A        = 7'h00;
  localparam logic [6:0] A_CHIP_TYPE    = 7'h03;
  localparam logic [6:0] A_XFER         = 7'h0f;
  localparam logic [6:0] A_IF_STATUS    = 7'h11;
  localparam logic [6:0] A_CFG_D        = 7'h14;
  localparam logic [6:0] A_ALARM_MASK   = 7'h16;
  localparam logic [6:0] A_ERR_STATUS   = 7'h17;
  localparam logic [6:0] A_PWRDN        = 7'h18;
  localparam logic [6:0] A_PRIMARY_LAST = 7'h1e;
  localparam logic [6:0] A_SECOND_FIRST = 7'h28;
  localparam logic [6:0] A_SECOND_LAST  = 7'h4b;
  localparam logic [6:0] A_HWLD16       = 7'h28;
  localparam logic [6:0] A_PSEL16       = 7'h29;
  localparam logic [6:0] A_OUT_LO       = 7'h2a;
  localparam logic [6:0] A_OUT_HI       = 7'h2b;
  localparam logic [6:0] A_IN_LO        = 7'h2c;
  localparam logic [6:0] A_IN_HI        = 7'h2d;
  localparam logic [6:0] A_SWLD         = 7'h2e;
  localparam logic [6:0] A_OPAGE_LO     = 7'h2f;
  localparam logic [6:0] A_OPAGE_HI     = 7'h30;
  localparam logic [6:0] A_IPAGE_LO     = 7'h31;
  localparam logic [6:0] A_IPAGE_HI     = 7'h32;
  localparam logic [6:0] A_HWLD24       = 7'h37;
  localparam logic [6:0] A_PSEL24       = 7'h38;
  // field positions
  localparam int B_SRST_HI = 7;
  localparam int B_SRST_LO = 0;
  localparam int B_LANE_DUAL = 0;
  localparam int B_PREC    = 0;
  localparam int B_PD      = 0;
  localparam int B_INV     = 0;
  localparam int B_PART    = 1;
  localparam int B_ROW     = 2;
  localparam int B_FCRC    = 3;
  localparam int B_CLKCNT  = 4;
  localparam int B_RST     = 0;
  localparam int B_REF     = 1;
  localparam int B_MCRC    = 2;
  localparam int B_DUAL    = 3;
  // reset values
  localparam logic [7:0] RST_CFG_A  = 8'h10;
  localparam logic [7:0] RST_XFER   = 8'h00;
  localparam logic [7:0] RST_CFG_D  = 8'h04;
  localparam logic [6:0] RST_MASK   = 7'h00;
  localparam logic [3:0] RST_ERR    = 4'h1;
  localparam logic [4:0] RST_STATUS = 5'h00;
  localparam logic [7:0] RST_PWRDN  = 8'h00;
  // chip type code: value is arbitrary
  localparam logic [7:0] CHIP_TYPE_VAL = 8'h5a;
  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int REF_LOW_MS    = 5;
  localparam int REF_LOW_CYC   = (CLK_HZ / 1000) * REF_LOW_MS;
  typedef enum logic [1:0] {LANE_1, LANE_2, LANE_4} lane_e;
  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_ABORT} phase_e;
endpackage : dac_ctl_pkg
`default_nettype wire

// ---- verilog/dac_update_reset_alarm_control.sv ----
// Purpose: register access, output update paths, power-down, resets and alarm
// Assumes: sclk runs only inside frames; mode 0 sampling on rising sclk edges
// Notes:   one event per data byte crosses by toggle; payload held until next byte
`timescale 1ns/1ps
`default_nettype none
module dac_update_reset_alarm_control
  import dac_ctl_pkg::*;
#(
  parameter int REF_LOW_CYCLES = REF_LOW_CYC
) (
  // core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  sdio_in,
  output logic      [3:0]  sdio_out,
  output logic      [3:0]  sdio_oe,
  input  wire logic        qspi_sel,
  // update strobe
  input  wire logic        load_strobe_n,
  // fault sources
  input  wire logic        ref_low,
  input  wire logic        frame_crc_fault,
  input  wire logic        mem_crc_fault,
  input  wire logic        init_fault,
  // converter side
  output logic      [15:0] dac_code,
  output logic             core_powered,
  output logic             alarm_n
);

  // core-domain state, declared first because the link side reads some of it
  logic [7:0]  cfg_a_reg, xfer_reg, cfg_d_reg, pwrdn_reg;
  logic [7:0]  hwld16_reg, hwld24_reg, psel16_reg, psel24_reg;
  logic [6:0]  mask_reg;
  logic [4:0]  status_reg;
  logic [3:0]  err_reg;
  logic [15:0] out_reg, in_reg;
  logic [7:0]  stage_reg;
  logic        pend_reg, core_on_reg, srst_reg, alarm_n_reg;
  logic [17:0] ref_cnt_reg;
  logic [4:0]  csync1_reg, csync2_reg;
  logic        cs_last_reg, ld_last_reg, tgl_last_reg;
  logic [1:0]  mode_reg;
  logic [7:0]  rd_mux;

  // ---------------- link clock domain ----------------
  logic       fresh_reg;
  logic [1:0] lsync1_reg, lsync2_reg;
  phase_e     phase_reg;
  logic [2:0] bits_reg;
  logic [7:0] sh_reg, tx_reg;
  logic [6:0] addr_reg;
  logic       rd_reg, part_lvl_reg;
  logic       evt_tgl_reg, evt_rd_reg, evt_fault_reg;
  logic [6:0] evt_addr_reg;
  logic [7:0] evt_data_reg;

  // sclk stands still between frames, so the strap is synchronised on core_clk
  // and frozen into mode_reg outside frames; the link side sees a steady level
  wire [1:0] lsync_in;
  assign lsync_in = {qspi_sel, xfer_reg[B_LANE_DUAL]};
  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_lsync
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          lsync1_reg[gl] <= 1'b0;
          lsync2_reg[gl] <= 1'b0;
        end else begin
          lsync1_reg[gl] <= lsync_in[gl];
          lsync2_reg[gl] <= lsync1_reg[gl];
        end
      end
    end
  endgenerate
  wire qspi_s = mode_reg[1];
  wire dual_s = mode_reg[0];

  // fresh marks the first sclk edge of a frame; set while cs_n is high
  always_ff @(posedge sclk or negedge rst_b or posedge cs_n) begin
    if (!rst_b) begin
      fresh_reg <= 1'b1;
    end else if (cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  wire phase_e ph_cur   = fresh_reg ? PH_INSTR : phase_reg;
  wire [2:0]   bits_cur = fresh_reg ? 3'd0 : bits_reg;
  wire         addr_sec = (addr_reg >= A_SECOND_FIRST) && (addr_reg <= A_SECOND_LAST);
  wire [6:0]   addr_inc = addr_reg + 7'd1;
  // stepping past the top of the secondary region heads for primary-only space
  wire         addr_inc_pri = (addr_inc <= A_PRIMARY_LAST) || (addr_inc > A_SECOND_LAST);

  lane_e lane_cur;
  always_comb begin
    if (qspi_s) begin
      lane_cur = LANE_4;
    end else if (ph_cur == PH_DATA && dual_s && addr_sec) begin
      lane_cur = LANE_2;
    end else begin
      lane_cur = LANE_1;
    end
  end

  logic [3:0] lanes_n;
  logic [7:0] sh_in, tx_shift;
  always_comb begin
    case (lane_cur)
      LANE_4: begin
        lanes_n  = 4'd4;
        sh_in    = {sh_reg[3:0], sdio_in[3:0]};
        tx_shift = {tx_reg[3:0], 4'h0};
      end
      LANE_2: begin
        lanes_n  = 4'd2;
        sh_in    = {sh_reg[5:0], sdio_in[1:0]};
        tx_shift = {tx_reg[5:0], 2'h0};
      end
      default: begin
        lanes_n  = 4'd1;
        sh_in    = {sh_reg[6:0], sdio_in[0]};
        tx_shift = {tx_reg[6:0], 1'h0};
      end
    endcase
  end

  wire [3:0] bits_sum  = {1'b0, bits_cur} + lanes_n;
  wire       byte_done = (bits_sum == 4'd8);
  wire [2:0] bits_nxt  = bits_sum[2:0];
  // dual lanes may not stream from the secondary into the primary region
  wire       dual_cross = !qspi_s && dual_s && addr_sec && addr_inc_pri;
  wire [6:0] rd_sel_addr = (ph_cur == PH_INSTR) ? sh_in[6:0] : addr_inc;

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg     <= PH_INSTR;
      bits_reg      <= 3'd0;
      sh_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      addr_reg      <= 7'h00;
      rd_reg        <= 1'b0;
      part_lvl_reg  <= 1'b0;
      evt_tgl_reg   <= 1'b0;
      evt_rd_reg    <= 1'b0;
      evt_fault_reg <= 1'b0;
      evt_addr_reg  <= 7'h00;
      evt_data_reg  <= 8'h00;
    end else begin
      bits_reg     <= bits_nxt;
      part_lvl_reg <= (bits_nxt != 3'd0);
      sh_reg       <= sh_in;
      case (ph_cur)
        PH_INSTR: begin
          phase_reg <= byte_done ? PH_DATA : PH_INSTR;
          if (byte_done) begin
            rd_reg   <= sh_in[7];
            addr_reg <= sh_in[6:0];
            tx_reg   <= rd_mux;
          end
        end
        PH_DATA: begin
          tx_reg <= tx_shift;
          if (byte_done) begin
            // the byte event fires on the edge that shifts its last bit
            evt_addr_reg  <= addr_reg;
            evt_data_reg  <= sh_in;
            evt_rd_reg    <= rd_reg;
            evt_fault_reg <= dual_cross;
            evt_tgl_reg   <= ~evt_tgl_reg;
            addr_reg      <= addr_inc;
            tx_reg        <= rd_mux;
            if (dual_cross) begin
              phase_reg <= PH_ABORT;
            end
          end
        end
        PH_ABORT: phase_reg <= PH_ABORT;
        default:  phase_reg <= PH_ABORT;
      endcase
    end
  end

  // read drive: lanes follow the same selection as writes; tri-state in reset
  wire drive = rst_b && !cs_n && !fresh_reg && (phase_reg == PH_DATA) && rd_reg;
  always_comb begin
    case (lane_cur)
      LANE_4: begin
        sdio_out = tx_reg[7:4];
        sdio_oe  = drive ? 4'hf : 4'h0;
      end
      LANE_2: begin
        sdio_out = {2'b00, tx_reg[7], tx_reg[6]};
        sdio_oe  = drive ? 4'h3 : 4'h0;
      end
      default: begin
        sdio_out = {2'b00, tx_reg[7], 1'b0};
        sdio_oe  = drive ? 4'h2 : 4'h0;
      end
    endcase
  end

  // ---------------- core clock domain ----------------
  // payload stays quasi-static: only read after its toggle is synchronised
  wire [4:0] csync_in = {cs_n, load_strobe_n, ref_low, evt_tgl_reg, part_lvl_reg};
  // syncs reset to each input's idle level so no false edge follows reset
  localparam logic [4:0] CSYNC_IDLE = 5'b11000;
  genvar gc;
  generate
    for (gc = 0; gc < 5; gc++) begin : g_csync
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          csync1_reg[gc] <= CSYNC_IDLE[gc];
          csync2_reg[gc] <= CSYNC_IDLE[gc];
        end else begin
          csync1_reg[gc] <= csync_in[gc];
          csync2_reg[gc] <= csync1_reg[gc];
        end
      end
    end
  endgenerate
  wire cs_s   = csync2_reg[4];
  wire ld_s   = csync2_reg[3];
  wire refl_s = csync2_reg[2];
  wire tgl_s  = csync2_reg[1];
  wire part_s = csync2_reg[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 2'b00;
    end else if (cs_s) begin
      mode_reg <= lsync2_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_last_reg  <= 1'b1;
      ld_last_reg  <= 1'b1;
      tgl_last_reg <= 1'b0;
    end else begin
      cs_last_reg  <= cs_s;
      ld_last_reg  <= ld_s;
      tgl_last_reg <= tgl_s;
    end
  end

  wire cs_rise = cs_s && !cs_last_reg;
  wire ld_fall = !ld_s && ld_last_reg;
  wire evt     = tgl_s ^ tgl_last_reg;
  wire ev_wr   = evt && !evt_rd_reg;

  function automatic logic addr_mapped(input logic [6:0] a);
    case (a)
      A_CFG_A, A_CHIP_TYPE, A_XFER, A_IF_STATUS, A_CFG_D, A_ALARM_MASK,
      A_ERR_STATUS, A_PWRDN, A_HWLD16, A_PSEL16, A_OUT_LO, A_OUT_HI,
      A_IN_LO, A_IN_HI, A_SWLD, A_OPAGE_LO, A_OPAGE_HI, A_IPAGE_LO,
      A_IPAGE_HI, A_HWLD24, A_PSEL24: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  wire [6:0] w_addr = evt_addr_reg;
  wire [7:0] w_data = evt_data_reg;
  wire       mapped = addr_mapped(w_addr);
  wire       is_lo  = (w_addr == A_OUT_LO) || (w_addr == A_IN_LO) ||
                      (w_addr == A_OPAGE_LO) || (w_addr == A_IPAGE_LO);
  wire       is_hi  = (w_addr == A_OUT_HI) || (w_addr == A_IN_HI) ||
                      (w_addr == A_OPAGE_HI) || (w_addr == A_IPAGE_HI);
  wire       commit = ev_wr && is_hi && pend_reg;
  wire [15:0] word  = {w_data, stage_reg};

  wire wr_cfg_a  = ev_wr && (w_addr == A_CFG_A);
  wire wr_status = ev_wr && (w_addr == A_IF_STATUS);
  wire wr_err    = ev_wr && (w_addr == A_ERR_STATUS);
  wire prec      = cfg_d_reg[B_PREC];
  wire hw_mask   = prec ? hwld24_reg[0] : hwld16_reg[0];
  wire page_sel  = prec ? psel24_reg[0] : psel16_reg[0];

  wire up_direct = commit && (w_addr == A_OUT_HI);
  wire up_opage  = commit && (w_addr == A_OPAGE_HI) && page_sel;
  wire ld_ipage  = commit && (w_addr == A_IPAGE_HI) && page_sel;
  wire ld_input  = commit && (w_addr == A_IN_HI);
  wire up_auto   = ld_input && !ld_s;
  wire up_sw     = ev_wr && (w_addr == A_SWLD);
  wire up_strobe = ld_fall && !hw_mask;
  wire any_up    = up_direct || up_opage || up_auto || up_sw || up_strobe;

  // soft reset takes one cycle and spares config A apart from its two reset bits, which self-clear
  wire srst_req  = wr_cfg_a && w_data[B_SRST_HI] && w_data[B_SRST_LO];
  wire clr       = srst_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      srst_reg  <= 1'b0;
      cfg_a_reg <= RST_CFG_A;
    end else begin
      srst_reg <= srst_req;
      if (srst_reg) begin
        cfg_a_reg[B_SRST_HI] <= 1'b0;
        cfg_a_reg[B_SRST_LO] <= 1'b0;
      end else if (wr_cfg_a) begin
        cfg_a_reg <= w_data;
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_reg <= RST_XFER;  cfg_d_reg <= RST_CFG_D;  pwrdn_reg <= RST_PWRDN;
      mask_reg <= RST_MASK;  hwld16_reg <= 8'h00;     hwld24_reg <= 8'h00;
      psel16_reg <= 8'h00;   psel24_reg <= 8'h00;
    end else if (clr) begin
      xfer_reg <= RST_XFER;  cfg_d_reg <= RST_CFG_D;  pwrdn_reg <= RST_PWRDN;
      mask_reg <= RST_MASK;  hwld16_reg <= 8'h00;     hwld24_reg <= 8'h00;
      psel16_reg <= 8'h00;   psel24_reg <= 8'h00;
    end else if (ev_wr) begin
      if (w_addr == A_XFER)       xfer_reg   <= w_data;
      if (w_addr == A_CFG_D)      cfg_d_reg  <= w_data;
      if (w_addr == A_PWRDN)      pwrdn_reg  <= w_data;
      if (w_addr == A_ALARM_MASK) mask_reg   <= w_data[6:0];
      if (w_addr == A_HWLD16)     hwld16_reg <= w_data;
      if (w_addr == A_HWLD24)     hwld24_reg <= w_data;
      if (w_addr == A_PSEL16)     psel16_reg <= w_data;
      if (w_addr == A_PSEL24)     psel24_reg <= w_data;
    end
  end

  // multibyte staging: low byte waits, high byte commits the word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= 8'h00;
      pend_reg  <= 1'b0;
    end else if (clr || cs_rise) begin
      pend_reg <= 1'b0;
    end else if (evt) begin
      pend_reg <= is_lo;
      if (is_lo) stage_reg <= w_data;
    end
  end

  // data path: direct writes beat strobe copies when they coincide
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_reg      <= 16'h0000;
      out_reg     <= 16'h0000;
      core_on_reg <= 1'b0;
    end else if (clr) begin
      in_reg      <= 16'h0000;
      out_reg     <= 16'h0000;
      core_on_reg <= 1'b0;
    end else begin
      if (ld_input || ld_ipage) in_reg <= word;
      if (up_direct || up_opage) begin
        out_reg <= word;
      end else if (up_auto) begin
        out_reg <= word;
      end else if (up_sw || up_strobe) begin
        out_reg <= in_reg;
      end
      if (any_up) core_on_reg <= 1'b1;
    end
  end

  // reference watchdog: only a low lasting past the limit counts
  wire ref_set = refl_s && (ref_cnt_reg == REF_LOW_CYCLES[17:0]);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_reg <= 18'h00000;
    end else if (!refl_s) begin
      ref_cnt_reg <= 18'h00000;
    end else if (!ref_set) begin
      ref_cnt_reg <= ref_cnt_reg + 18'h00001;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  logic [4:0] st_set;
  logic [3:0] er_set;
  always_comb begin
    st_set          = 5'h00;
    st_set[B_INV]   = evt && !mapped;
    st_set[B_PART]  = cs_rise && pend_reg;
    st_set[B_ROW]   = ev_wr && (w_addr == A_CHIP_TYPE);
    st_set[B_FCRC]  = frame_crc_fault;
    st_set[B_CLKCNT] = cs_rise && part_s;
    er_set          = 4'h0;
    er_set[B_RST]   = srst_reg;
    er_set[B_REF]   = ref_set;
    er_set[B_MCRC]  = mem_crc_fault;
    er_set[B_DUAL]  = evt && evt_fault_reg;
  end
  wire [4:0] st_clr = wr_status ? w_data[4:0] : 5'h00;
  wire [3:0] er_clr = wr_err ? w_data[3:0] : 4'h0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= RST_STATUS;
      err_reg    <= RST_ERR;
    end else if (clr) begin
      status_reg <= RST_STATUS;
      err_reg    <= RST_ERR;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
      err_reg    <= (err_reg & ~er_clr) | er_set;
    end
  end

  // mask 0 lets an error through, except the dual-lane error, which never alarms; the flag is kept either way
  wire [6:0] alarm_src = {err_reg[B_REF], status_reg[B_CLKCNT], err_reg[B_MCRC],
                          status_reg[B_FCRC], status_reg[B_ROW], status_reg[B_PART],
                          status_reg[B_INV]};
  wire alarm = |(alarm_src & ~mask_reg) ||
               err_reg[B_RST] || init_fault;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_n_reg <= 1'b0;
    end else begin
      alarm_n_reg <= !alarm;
    end
  end

  assign alarm_n      = alarm_n_reg;
  assign dac_code     = out_reg;
  assign core_powered = core_on_reg && !pwrdn_reg[B_PD];

  // readback mux sampled at sclk byte edges; registers are quasi-static then,
  // so a flag changing mid-read may be caught either way
  always_comb begin
    case (rd_sel_addr)
      A_CFG_A:      rd_mux = cfg_a_reg;
      A_CHIP_TYPE:  rd_mux = CHIP_TYPE_VAL;
      A_XFER:       rd_mux = xfer_reg;
      A_IF_STATUS:  rd_mux = {3'b000, status_reg};
      A_CFG_D:      rd_mux = cfg_d_reg;
      A_ALARM_MASK: rd_mux = {1'b0, mask_reg};
      A_ERR_STATUS: rd_mux = {4'h0, err_reg};
      A_PWRDN:      rd_mux = pwrdn_reg;
      A_HWLD16:     rd_mux = hwld16_reg;
      A_PSEL16:     rd_mux = psel16_reg;
      A_OUT_LO:     rd_mux = out_reg[7:0];
      A_OUT_HI:     rd_mux = out_reg[15:8];
      A_IN_LO:      rd_mux = in_reg[7:0];
      A_IN_HI:      rd_mux = in_reg[15:8];
      A_HWLD24:     rd_mux = hwld24_reg;
      A_PSEL24:     rd_mux = psel24_reg;
      default:      rd_mux = 8'h00;
    endcase
  end

endmodule : dac_update_reset_alarm_control
`default_nettype wire

// ---- verif/spi_host_model.sv ----
// Purpose: host controller model that drives the serial link in frames
// Assumes: mode 0, lanes change while sclk is low, device samples on rising sclk
// Notes:   link clock stands still between bytes and frames; bytes 100 ns apart
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // link lines
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      lanes,
  // device side
  input  wire logic [3:0] sdio_out,
  input  wire logic       quad
);
  logic dual;
  initial begin
    dual  = 1'b0;
    sclk  = 1'b0;
    cs_n  = 1'b1;
    lanes = 4'h0;
  end
  // one lane unless the quad pin is high, or dual is set for a secondary-region data byte (two lanes); unused lanes toggle so they never look held
  task automatic shift(input logic [7:0] b, input int w, inout logic [7:0] q);
    for (int i = 7; i >= 0; i -= w) begin
      if (w == 4) lanes = b[i-:4];
      else if (w == 2) lanes = {~lanes[3:2], b[i-:2]};
      else lanes = {~lanes[3:1], b[i]};
      #6;
      if (w == 4) q = {q[3:0], sdio_out};
      else if (w == 2) q = {q[5:0], sdio_out[1:0]};
      else q = {q[6:0], sdio_out[1]};
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
  endtask : shift
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d,
                      input int n, output logic [7:0] q);
    int dw;
    dw = quad ? 4 : ((dual && a >= 7'h28 && a <= 7'h4b) ? 2 : 1);
    q = 8'h00;
    cs_n = 1'b0;
    #10;
    shift({rd, a}, quad ? 4 : 1, q);
    for (int k = 0; k < n; k++) begin
      #100;
      shift(d[8*k+:8], dw, q);
    end
    #100;
    cs_n = 1'b1;
    lanes = ~lanes;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ---- verif/dac_ctl_sva.sv ----
// Purpose: port checks for the update, reset and alarm control
// Assumes: bound to the top module, core clock domain only
// Notes:   quiet_cnt counts cycles free of frames, strobe and init fault
`timescale 1ns/1ps
`default_nettype none
module dac_ctl_sva (
  // watched inputs
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        cs_n,
  input wire logic        qspi_sel,
  input wire logic        load_strobe_n,
  input wire logic        init_fault,
  // watched outputs
  input wire logic [3:0]  sdio_oe,
  input wire logic [15:0] dac_code,
  input wire logic        core_powered,
  input wire logic        alarm_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic [3:0] quiet_cnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) quiet_cnt <= 4'h0;
    else if (!cs_n || !load_strobe_n || init_fault) quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
  end
  property p_rst_vals; $rose(rst_b) |-> dac_code == 16'h0000 && !core_powered && !alarm_n; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared");
  property p_oe_idle; cs_n |-> sdio_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lane driven outside frame");
  property p_oe_single; !qspi_sel && $stable(qspi_sel) |-> sdio_oe inside {4'h0, 4'h2, 4'h3}; endproperty
  a_oe_single: assert property (p_oe_single) else $error("bad lanes, quad pin low");
  property p_oe_quad; qspi_sel && !cs_n && sdio_oe != 4'h0 |-> sdio_oe == 4'hf; endproperty
  a_oe_quad: assert property (p_oe_quad) else $error("bad lanes, quad pin high");
  property p_init; init_fault |=> !alarm_n; endproperty
  a_init: assert property (p_init) else $error("alarm missing on init fault");
  property p_alarm_hold; !alarm_n && quiet_cnt == 4'hf |=> !alarm_n; endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm cleared by itself");
  property p_code_quiet; quiet_cnt == 4'hf |=> $stable(dac_code); endproperty
  a_code_quiet: assert property (p_code_quiet) else $error("output moved");
  property p_pwr_quiet; quiet_cnt == 4'hf |=> $stable(core_powered); endproperty
  a_pwr_quiet: assert property (p_pwr_quiet) else $error("core power moved");
endmodule : dac_ctl_sva
bind dac_update_reset_alarm_control dac_ctl_sva u_sva (.core_clk, .rst_b, .cs_n, .qspi_sel,
  .load_strobe_n, .init_fault, .sdio_oe, .dac_code, .core_powered, .alarm_n);
`default_nettype wire

// ---- verif/test_dac_update_reset_alarm_control.sv ----
// Purpose: self-checking bench for the update, reset and alarm control
// Assumes: host model drives frames; reference filter shortened to 20 cycles
// Notes:   expected values come from the register map, never from the design
`timescale 1ns/1ps
`default_nettype none
module test_dac_update_reset_alarm_control;
  logic             core_clk, rst_b, qspi_sel, load_strobe_n, ref_low;
  logic             frame_crc_fault, mem_crc_fault, init_fault;
  wire logic        sclk, cs_n, core_powered, alarm_n;
  wire logic [3:0]  host_drv, sdio_out, sdio_oe, sdio_in;
  wire logic [15:0] dac_code;
  int               error_cnt, checked;
  logic [7:0]       q;
  // read flag, address, write data, expected read
  logic [27:0] rows [22] = '{28'h1_00_00_10, 28'h1_03_00_5a, 28'h1_14_00_04, 28'h1_16_00_00,
    28'h1_17_00_01, 28'h1_11_00_00, 28'h1_18_00_00, 28'h0_17_01_00, 28'h1_17_00_00,
    28'h0_16_7f_00, 28'h1_16_00_7f, 28'h0_03_ff_00, 28'h1_11_00_04, 28'h1_03_00_5a,
    28'h0_11_04_00, 28'h0_20_00_00, 28'h1_11_00_01, 28'h0_11_01_00, 28'h0_2a_00_00,
    28'h1_11_00_02, 28'h0_11_02_00, 28'h1_11_00_00};
  // device lanes win the wire while enabled
  assign sdio_in = (sdio_oe & sdio_out) | (~sdio_oe & host_drv);
  dac_update_reset_alarm_control #(.REF_LOW_CYCLES(20)) uut (.core_clk, .rst_b, .sclk, .cs_n,
    .sdio_in, .sdio_out, .sdio_oe, .qspi_sel, .load_strobe_n, .ref_low, .frame_crc_fault,
    .mem_crc_fault, .init_fault, .dac_code, .core_powered, .alarm_n);
  spi_host_model host (.sclk, .cs_n, .lanes(host_drv), .sdio_out, .quad(qspi_sel));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk_al(input logic e);
    chk({15'h0000, alarm_n}, {15'h0000, e});
  endtask : chk_al
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
    host.xfer(1'b0, a, d, n, q);
    repeat (6) @(posedge core_clk);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 16'h0000, 1, q);
    repeat (6) @(posedge core_clk);
    chk({8'h00, q}, {8'h00, e});
  endtask : rdc
  task automatic strobe;
    load_strobe_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    load_strobe_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : strobe
  task final_report;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    {rst_b, qspi_sel, ref_low, frame_crc_fault, mem_crc_fault, init_fault} = 6'h00;
    load_strobe_n = 1'b1;
    repeat (10) @(posedge core_clk);
    chk({dac_code[13:0], core_powered, alarm_n}, 16'h0000);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i][24]) rdc(rows[i][22:16], rows[i][7:0]);
      else wr(rows[i][22:16], {8'h00, rows[i][15:8]}, 1);
    end
    chk_al(1'b1);
    frame_crc_fault <= 1'b1;
    mem_crc_fault <= 1'b1;
    @(posedge core_clk);
    {frame_crc_fault, mem_crc_fault} <= 2'b00;
    repeat (4) @(posedge core_clk);
    chk_al(1'b1);
    rdc(7'h11, 8'h08);
    wr(7'h16, 16'h0008, 1);
    chk_al(1'b0);
    wr(7'h17, 16'h0004, 1);
    chk_al(1'b1);
    wr(7'h16, 16'h0000, 1);
    chk_al(1'b0);
    wr(7'h11, 16'h0008, 1);
    chk_al(1'b1);
    wr(7'h2a, 16'h1234, 2);
    chk({dac_code[14:0], core_powered}, 16'h2469);
    wr(7'h2c, 16'h5678, 2);
    chk(dac_code, 16'h1234);
    wr(7'h2e, 16'h0000, 1);
    chk(dac_code, 16'h5678);
    load_strobe_n <= 1'b0;
    wr(7'h2c, 16'h9abc, 2);
    chk(dac_code, 16'h9abc);
    load_strobe_n <= 1'b1;
    wr(7'h28, 16'h0000, 1);
    wr(7'h2c, 16'h1111, 2);
    strobe();
    chk(dac_code, 16'h1111);
    wr(7'h28, 16'h0001, 1);
    wr(7'h2c, 16'h2222, 2);
    strobe();
    chk(dac_code, 16'h1111);
    wr(7'h29, 16'h0001, 1);
    wr(7'h2f, 16'h3333, 2);
    chk(dac_code, 16'h3333);
    wr(7'h31, 16'h4444, 2);
    chk(dac_code, 16'h3333);
    wr(7'h2e, 16'h0000, 1);
    chk(dac_code, 16'h4444);
    wr(7'h29, 16'h0000, 1);
    wr(7'h2f, 16'h5555, 2);
    chk(dac_code, 16'h4444);
    ref_low <= 1'b1;
    repeat (12) @(posedge core_clk);
    ref_low <= 1'b0;
    rdc(7'h17, 8'h00);
    ref_low <= 1'b1;
    repeat (40) @(posedge core_clk);
    ref_low <= 1'b0;
    rdc(7'h17, 8'h02);
    chk_al(1'b0);
    wr(7'h17, 16'h0002, 1);
    wr(7'h0f, 16'h0001, 1);
    host.dual = 1'b1;
    wr(7'h4b, 16'h00c3, 1);
    rdc(7'h17, 8'h08);
    host.dual = 1'b0;
    init_fault <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_al(1'b0);
    init_fault <= 1'b0;
    wr(7'h00, 16'h0091, 1);
    chk({dac_code[13:0], core_powered, alarm_n}, 16'h0000);
    rdc(7'h00, 8'h10);
    rdc(7'h17, 8'h01);
    qspi_sel <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(7'h2a, 16'ha5c3, 2);
    chk(dac_code, 16'ha5c3);
    rdc(7'h16, 8'h00);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({dac_code[14:0], alarm_n}, 16'h0000);
    final_report();
  end
endmodule : test_dac_update_reset_alarm_control
`default_nettype wire
